// File: design/snsd_decoder.sv
// Top: switch bank decoder for multidrop address and bit rate
// Overview of operation
// - Switches one to six form node address
// - Switches seven, eight form bit-rate code
// - Switches never touch point-to-point port settings
// - Address zero selects stored non-volatile address
// - Rate code zero selects stored non-volatile rate
// - Codes 1,2,3 give 9.6, 38.4, 115.2 kbps
`timescale 1ns/1ns
module snsd_decoder (
  input  wire logic                  clk,
  input  wire logic                  rst_n,
  input  wire logic [snsd_pkg::SW_W-1:0]    switchOn,
  input  wire logic                  portSelect_n,
  input  wire logic [snsd_pkg::ADDR_W-1:0]  nvmAddr,
  input  wire logic [snsd_pkg::PRESC_W-1:0] nvmRateDiv,
  input  wire logic [snsd_pkg::PRESC_W-1:0] p2pRateDiv,
  output logic      [snsd_pkg::ADDR_W-1:0]  nodeAddr,
  output logic      [snsd_pkg::RATE_W-1:0]  rateCode,
  output logic                       addrFromNvm,
  output logic                       rateFromNvm,
  output logic      [snsd_pkg::PRESC_W-1:0] mdRateDiv,
  output logic                       multidropSel,
  output logic      [snsd_pkg::PRESC_W-1:0] portRateDiv,
  output logic                       cfgValid
);
  import snsd_pkg::*;

  logic [SW_W-1:0]    switchSync;
  logic               mdReqSync;
  snsd_state_e        state;
  snsd_state_e        next_state;
  logic [ADDR_W-1:0]  swAddr;
  logic [RATE_W-1:0]  swRate;
  logic [PRESC_W-1:0] next_mdRateDiv;

  // A divisor wider than the prescaler would be cut and silently give a wrong rate
  if (CLK_HZ / RATE1_BPS >= (1 << PRESC_W) || SW_W != ADDR_W + RATE_W ||
      RATE_LSB != ADDR_LSB + ADDR_W) begin : g_bad_widths
    $error("Switch fields or divisors do not fit the configured widths");
  end

  // Select is inverted ahead of the synchroniser so its reset value means point-to-point
  snsd_sync #(.W(SW_W + 1)) uSync (
    .clk  (clk),
    .rst_n(rst_n),
    .din  ({~portSelect_n, switchOn}),
    .dout ({mdReqSync, switchSync})
  );

  assign swAddr = switchSync[ADDR_LSB +: ADDR_W];
  assign swRate = switchSync[RATE_LSB +: RATE_W];

  // Two idle states let both synchroniser stages fill before the single capture
  always_comb begin
    case (state)
      SNSD_WAIT:   next_state = SNSD_SETTLE;
      SNSD_SETTLE: next_state = SNSD_SAMPLE;
      SNSD_SAMPLE: next_state = SNSD_HOLD;
      SNSD_HOLD:   next_state = SNSD_HOLD;
      default:     next_state = SNSD_HOLD;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= SNSD_WAIT;
    end else begin
      state <= next_state;
    end
  end

  always_comb begin
    case (swRate)
      CODE_9K6:   next_mdRateDiv = DIV1;
      CODE_38K4:  next_mdRateDiv = DIV2;
      CODE_115K2: next_mdRateDiv = DIV3;
      default:    next_mdRateDiv = nvmRateDiv;
    endcase
  end

  // Captured only once; later switch moves are ignored until reset
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      nodeAddr    <= ADDR_RST;
      rateCode    <= RATE_RST;
      addrFromNvm <= 1'b0;
      rateFromNvm <= 1'b0;
      mdRateDiv   <= '0;
      cfgValid    <= 1'b0;
    end else if (state == SNSD_SAMPLE) begin
      nodeAddr    <= (swAddr == ADDR_RST) ? nvmAddr : swAddr;
      addrFromNvm <= (swAddr == ADDR_RST);
      rateCode    <= swRate;
      rateFromNvm <= (swRate == CODE_NVM);
      mdRateDiv   <= next_mdRateDiv;
      cfgValid    <= 1'b1;
    end
  end

  // Port choice follows the select pin; point-to-point rate ignores switches
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      multidropSel <= 1'b0;
      portRateDiv  <= '0;
    end else begin
      multidropSel <= mdReqSync;
      portRateDiv  <= mdReqSync ? mdRateDiv : p2pRateDiv;
    end
  end
endmodule : snsd_decoder

// File: design/snsd_pkg.sv
// Package: constants for the serial node setting decoder
package snsd_pkg;
  localparam int ADDR_W       = 6;
  localparam int RATE_W       = 2;
  localparam int SW_W         = 8;
  localparam int ADDR_LSB     = 0;
  localparam int RATE_LSB     = 6;
  localparam int PRESC_W      = 16;
  localparam int CLK_HZ       = 250000000;
  // Fixed multidrop rates in bits per second
  localparam int RATE1_BPS    = 9600;
  localparam int RATE2_BPS    = 38400;
  localparam int RATE3_BPS    = 115200;
  // Bit-period divisors derived from the clock rate (rounded down)
  localparam logic [PRESC_W-1:0] DIV1 = PRESC_W'(CLK_HZ / RATE1_BPS);
  localparam logic [PRESC_W-1:0] DIV2 = PRESC_W'(CLK_HZ / RATE2_BPS);
  localparam logic [PRESC_W-1:0] DIV3 = PRESC_W'(CLK_HZ / RATE3_BPS);
  localparam logic [5:0]  ADDR_RST    = 6'h00;
  localparam logic [1:0]  RATE_RST    = 2'h0;
  localparam logic [1:0]  CODE_NVM    = 2'h0;
  localparam logic [1:0]  CODE_9K6    = 2'h1;
  localparam logic [1:0]  CODE_38K4   = 2'h2;
  localparam logic [1:0]  CODE_115K2  = 2'h3;
  typedef enum logic [1:0] {SNSD_WAIT, SNSD_SETTLE, SNSD_SAMPLE, SNSD_HOLD} snsd_state_e;
endpackage : snsd_pkg

// File: design/snsd_sync.sv
// Two-flop synchroniser for a bus of static pins
`timescale 1ns/1ns
module snsd_sync #(
  parameter int W = 8
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);
  logic [W-1:0] stage1;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      stage1 <= '0;
      dout   <= '0;
    end else begin
      stage1 <= din;
      dout   <= stage1;
    end
  end
endmodule : snsd_sync

// File: verif/snsd_decoder_bench.sv
// Bench: switch settings across resets, then late switch flips
`timescale 1ns/1ns
module snsd_decoder_bench;
  logic        clk = 1'b0, rst_n = 1'b0, selSet = 1'b1, portSelect_n, addrFromNvm;
  logic        rateFromNvm, multidropSel, cfgValid;
  logic [7:0]  swSet = 8'h00, switchOn;
  logic [5:0]  nvmAddr, nodeAddr;
  logic [1:0]  rateCode;
  logic [15:0] nvmRateDiv, mdRateDiv, portRateDiv, p2pRateDiv = 16'h0ABC, expDiv;
  logic [43:0] exp, got;
  int          errors = 0, num_checks = 0;
  always #2 clk = ~clk;
  snsd_partner i_part (.*);
  snsd_decoder i_dut (.*);
  task automatic complete_run;
    if (errors == 0 && num_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : complete_run
  task automatic run_case(input logic [7:0] sw, input logic sel);
    int n;
    expDiv = sw[7:6] == 2'h1 ? 16'h65B9 : sw[7:6] == 2'h2 ? 16'h196E :
             sw[7:6] == 2'h3 ? 16'h087A : 16'h1234;
    exp = {(sw[5:0] == 6'h00) ? 6'h2A : sw[5:0], sw[7:6], sw[5:0] == 6'h00, sw[7:6] == 2'h0,
           !sel, expDiv, sel ? 16'h0ABC : expDiv, 1'b1};
    @(posedge clk) rst_n <= 1'b0;
    swSet <= sw;
    selSet <= sel;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    for (n = 0; n < 20 && cfgValid !== 1'b1; n++) @(posedge clk);
    // Flipping every switch after capture must leave the outputs alone
    repeat (6) @(posedge clk) swSet <= ~sw;
    @(negedge clk) num_checks++;
    got = {nodeAddr, rateCode, addrFromNvm, rateFromNvm, multidropSel, mdRateDiv, portRateDiv,
           cfgValid};
    if (got !== exp) begin
      $display("MISMATCH %0t %h %h", $time, got, exp);
      errors++;
    end
  endtask : run_case
  task automatic stored_both;
    run_case(8'h00, 1'b0);
  endtask : stored_both
  task automatic slow_p2p;
    run_case(8'h41, 1'b1);
  endtask : slow_p2p
  task automatic mid_multidrop;
    run_case(8'hBF, 1'b0);
  endtask : mid_multidrop
  task automatic fast_p2p;
    run_case(8'hE5, 1'b1);
  endtask : fast_p2p
  // Each field falls back to the stored value on its own, not only both together
  task automatic split_sources;
    run_case(8'h80, 1'b0);
    run_case(8'h07, 1'b1);
  endtask : split_sources
  initial begin
    stored_both();
    slow_p2p();
    mid_multidrop();
    fast_p2p();
    split_sources();
    complete_run();
  end
  initial begin
    #20000 errors++;
    complete_run();
  end
endmodule : snsd_decoder_bench

// File: verif/snsd_decoder_properties.sv
// Checker: relations between switch pins, stored values and decoded outputs
`timescale 1ns/1ns
module snsd_chk (
  input wire logic        clk,
  input wire logic        rst_n,
  input wire logic [7:0]  switchOn,
  input wire logic [5:0]  nvmAddr,
  input wire logic [15:0] nvmRateDiv,
  input wire logic [15:0] p2pRateDiv,
  input wire logic [5:0]  nodeAddr,
  input wire logic [1:0]  rateCode,
  input wire logic        addrFromNvm,
  input wire logic        rateFromNvm,
  input wire logic [15:0] mdRateDiv,
  input wire logic        multidropSel,
  input wire logic [15:0] portRateDiv,
  input wire logic        cfgValid
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  AST_ADDR: assert property ($rose(cfgValid) |->
    nodeAddr == (switchOn[5:0] == 6'h00 ? nvmAddr : switchOn[5:0])) else $error("bad address");
  AST_CODE: assert property ($rose(cfgValid) |-> rateCode == switchOn[7:6])
    else $error("bad rate code");
  AST_ANVM: assert property ($rose(cfgValid) |-> addrFromNvm == (switchOn[5:0] == 6'h00))
    else $error("bad address source");
  AST_RNVM: assert property ($rose(cfgValid) |-> rateFromNvm == (switchOn[7:6] == 2'h0))
    else $error("bad rate source");
  AST_DIV: assert property (cfgValid |-> mdRateDiv == (rateCode == 2'h1 ? 16'h65B9 :
    rateCode == 2'h2 ? 16'h196E : rateCode == 2'h3 ? 16'h087A : nvmRateDiv)) else $error("bad div");
  AST_P2P: assert property (!multidropSel && $past(rst_n) && $stable(p2pRateDiv) |->
    portRateDiv == p2pRateDiv) else $error("p2p rate disturbed");
  AST_HOLD: assert property (cfgValid && $past(cfgValid) |->
    $stable({nodeAddr, rateCode, addrFromNvm, mdRateDiv})) else $error("capture not held");
endmodule : snsd_chk
bind snsd_decoder snsd_chk i_chk (.*);

// File: verif/snsd_partner.sv
// Partner: setting switch bank, port select pin and stored values
`timescale 1ns/1ns
module snsd_partner (
  input  wire logic        clk,
  input  wire logic [7:0]  swSet,
  input  wire logic        selSet,
  output logic      [7:0]  switchOn = 8'h00,
  output logic             portSelect_n = 1'b1,
  output logic      [5:0]  nvmAddr,
  output logic      [15:0] nvmRateDiv
);
  // Pins move on an edge only, so a flip never races the sampler
  always @(posedge clk) switchOn <= swSet;
  always @(posedge clk) portSelect_n <= selSet;
  assign nvmAddr = 6'h2A;
  assign nvmRateDiv = 16'h1234;
endmodule : snsd_partner
